/* File: core/dci_top.sv */
// mode registers for low-byte calibration invert, partial-refresh masks and strobe oscillator count
// assumes: command pins arrive from the controller, sampled on rising edges of its clock ck_i;
// refresh query, oscillator and calibration inputs come from logic on ref_clk_i
`include "dci_regs.svh"
module dci_top
  import dci_pkg::*;
#(
  parameter int NUM_CH = 2
)(
  input  wire logic                         ref_clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         ck_i,
  input  wire logic                         cmd_valid_i,
  input  wire logic [1:0]                   cmd_code_i,
  input  wire logic [$clog2(NUM_CH)-1:0]    cmd_chan_i,
  input  wire logic [5:0]                   cmd_addr_i,
  input  wire logic [7:0]                   cmd_op_i,
  output logic                              rd_valid_o,
  output logic [7:0]                        rd_dq_o,
  input  wire logic                         osc_done_i,
  input  wire logic [15:0]                  osc_count_i,
  input  wire logic [NUM_CH-1:0][2:0]       density_i,
  input  wire logic                         rfq_valid_i,
  input  wire logic [$clog2(NUM_CH)-1:0]    rfq_chan_i,
  input  wire logic [2:0]                   rfq_bank_i,
  input  wire logic [16:0]                  rfq_row_i,
  output logic                              rfq_skip_o,
  output logic [NUM_CH-1:0][7:0]            bank_mask_o,
  output logic [NUM_CH-1:0][7:0]            seg_mask_o,
  input  wire logic                         cal_active_i,
  input  wire logic                         cal_pat_sel_b_i,
  input  wire logic                         cal_pat_a_bit_i,
  input  wire logic                         cal_pat_b_bit_i,
  input  wire logic                         bus_inv_en_i,
  input  wire logic [7:0]                   rd_byte_i,
  output logic [7:0]                        dq_lane_o,
  output logic                              mask_lane_o
);
  localparam int CW = $clog2(NUM_CH);
  localparam int PW = 18 + CW;

  // two-stage synchroniser for the clock and command pins
  // the command word rides the same two flops as ck_i; it is held steady around the
  // rise, so the word read at the detected edge is whole even though it is multi-bit
  logic [PW-1:0] pin_s1_r;
  logic [PW-1:0] pin_s2_r;
  logic          ck_d_r;
  logic          ck_s;
  logic          valid_s;
  dci_cmd_type   code_s;
  logic [CW-1:0] chan_s;
  logic [5:0]    addr_s;
  logic [7:0]    op_s;
  logic          take;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ck_d_r   <= 1'b0;
    end else begin
      pin_s1_r <= {ck_i, cmd_valid_i, cmd_code_i, cmd_chan_i, cmd_addr_i, cmd_op_i};
      pin_s2_r <= pin_s1_r;
      ck_d_r   <= pin_s2_r[PW-1];
    end
  end

  always_comb begin
    ck_s    = pin_s2_r[PW-1];
    valid_s = pin_s2_r[PW-2];
    code_s  = dci_cmd_type'(pin_s2_r[PW-3 -: 2]);
    chan_s  = pin_s2_r[14+CW-1 -: CW];
    addr_s  = pin_s2_r[13:8];
    op_s    = pin_s2_r[7:0];
    // a channel beyond NUM_CH is dropped rather than aliased onto a real one
    take    = ck_s && !ck_d_r && valid_s && (int'(chan_s) < NUM_CH);
  end

  // register state
  dci_byte_type              invert_r;
  dci_byte_type              invert_nxt;
  logic [NUM_CH-1:0][7:0]    bank_r;
  logic [NUM_CH-1:0][7:0]    bank_nxt;
  logic [NUM_CH-1:0][7:0]    seg_r;
  logic [NUM_CH-1:0][7:0]    seg_nxt;
  dci_byte_type              cnt_lo_r;
  dci_byte_type              cnt_lo_nxt;
  dci_byte_type              cnt_hi_r;
  dci_byte_type              cnt_hi_nxt;
  logic                      rd_valid_r;
  logic                      rd_valid_nxt;
  dci_byte_type              rd_dq_r;
  dci_byte_type              rd_dq_nxt;
  logic                      skip_r;
  logic                      skip_nxt;

  always_comb begin
    invert_nxt   = invert_r;
    bank_nxt     = bank_r;
    seg_nxt      = seg_r;
    cnt_lo_nxt   = cnt_lo_r;
    cnt_hi_nxt   = cnt_hi_r;
    rd_valid_nxt = 1'b0;
    rd_dq_nxt    = rd_dq_r;
    if (take && code_s == DCI_CMD_MRW) begin
      if (addr_s == `DCI_MA_LOW_INVERT) begin
        invert_nxt = op_s;                                                     // RQ1
      end else if (addr_s == `DCI_MA_BANK_MASK) begin
        bank_nxt[chan_s] = op_s;                                               // RQ6 RQ7
      end else if (addr_s == `DCI_MA_SEG_MASK) begin
        seg_nxt[chan_s] = op_s;                                                // RQ8 RQ10
      end
    end
    if (take && code_s == DCI_CMD_MRR) begin
      rd_valid_nxt = 1'b1;
      if (addr_s == `DCI_MA_CNT_LOW) begin
        rd_dq_nxt = cnt_lo_r;                                                  // RQ12 RQ16
      end else if (addr_s == `DCI_MA_CNT_HIGH) begin
        rd_dq_nxt = cnt_hi_r;                                                  // RQ12 RQ16
      end else begin
        rd_dq_nxt = 8'h00;                                                     // RQ17
      end
    end
    if (take && code_s == DCI_CMD_OSC_MPC) begin
      cnt_lo_nxt = `DCI_CNT_RST;                                               // RQ14
      cnt_hi_nxt = `DCI_CNT_RST;
    end
    // a finished run in the same cycle as a restart is kept, not lost
    if (osc_done_i) begin
      cnt_lo_nxt = osc_count_i[7:0];                                           // RQ12
      cnt_hi_nxt = osc_count_i[15:8];
    end
    // the answer uses the masks as they stand now; a write in the same cycle counts next time
    skip_nxt = 1'b0;
    if (rfq_valid_i && int'(rfq_chan_i) < NUM_CH) begin
      skip_nxt = bank_r[rfq_chan_i][rfq_bank_i] ||                             // RQ6
                 seg_r[rfq_chan_i][dci_seg_of(density_i[rfq_chan_i], rfq_row_i)]; // RQ9
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      invert_r   <= `DCI_INVERT_RST;                                           // RQ3
      bank_r     <= '0;
      seg_r      <= '0;
      cnt_lo_r   <= `DCI_CNT_RST;
      cnt_hi_r   <= `DCI_CNT_RST;
      rd_valid_r <= 1'b0;
      rd_dq_r    <= 8'h00;
      skip_r     <= 1'b0;
    end else begin
      invert_r   <= invert_nxt;
      bank_r     <= bank_nxt;
      seg_r      <= seg_nxt;
      cnt_lo_r   <= cnt_lo_nxt;
      cnt_hi_r   <= cnt_hi_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_dq_r    <= rd_dq_nxt;
      skip_r     <= skip_nxt;
    end
  end

  assign rd_valid_o  = rd_valid_r;
  assign rd_dq_o     = rd_dq_r;
  assign rfq_skip_o  = skip_r;
  assign bank_mask_o = bank_r;
  assign seg_mask_o  = seg_r;

  dci_cal_if cal_bus ();
  assign cal_bus.invert_mask = invert_r;                                       // RQ2
  assign cal_bus.cal_active  = cal_active_i;
  assign cal_bus.pat_sel_b   = cal_pat_sel_b_i;
  assign cal_bus.pat_a_bit   = cal_pat_a_bit_i;
  assign cal_bus.pat_b_bit   = cal_pat_b_bit_i;
  assign cal_bus.bus_inv_en  = bus_inv_en_i;
  assign cal_bus.rd_byte     = rd_byte_i;
  assign dq_lane_o           = cal_bus.dq_lane;
  assign mask_lane_o         = cal_bus.mask_lane;

  dci_cal_lane u_lane (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .cal       (cal_bus.lane)
  );

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_invert_default: assert property ( // RQ3
    $past(reset_i) |-> invert_r == `DCI_INVERT_RST)
    else $error("invert register not at default after reset");
  a_invert_write: assert property ( // RQ1
    take && code_s == DCI_CMD_MRW && addr_s == `DCI_MA_LOW_INVERT |=> invert_r == $past(op_s))
    else $error("invert register write lost");
  a_bank_per_chan: assert property ( // RQ7
    take && code_s == DCI_CMD_MRW && addr_s == `DCI_MA_BANK_MASK
    |=> bank_r[$past(chan_s)] == $past(op_s) && bank_r[!$past(chan_s)] == $past(bank_r[!chan_s]))
    else $error("bank mask written to wrong channel");
  a_seg_write: assert property ( // RQ10
    take && code_s == DCI_CMD_MRW && addr_s == `DCI_MA_SEG_MASK |=> seg_r[$past(chan_s)] == $past(op_s))
    else $error("segment mask write lost");
  a_bank_skip: assert property ( // RQ6
    rfq_valid_i && bank_r[rfq_chan_i][rfq_bank_i] |=> rfq_skip_o)
    else $error("masked bank not skipped");
  a_seg_skip_top: assert property ( // RQ9
    rfq_valid_i && density_i[rfq_chan_i] == 3'h7 && seg_r[rfq_chan_i][rfq_row_i[16:14]] |=> rfq_skip_o)
    else $error("masked segment not skipped");
  a_osc_clear: assert property ( // RQ14
    take && code_s == DCI_CMD_OSC_MPC && !osc_done_i |=> cnt_lo_r == 8'h00 && cnt_hi_r == 8'h00)
    else $error("count not cleared by start command");
  a_read_count: assert property ( // RQ16
    take && code_s == DCI_CMD_MRR && addr_s == `DCI_MA_CNT_HIGH |=> rd_valid_o && rd_dq_o == $past(cnt_hi_r))
    else $error("count high byte read wrong");
  a_read_wo_zero: assert property ( // RQ17
    take && code_s == DCI_CMD_MRR && addr_s == `DCI_MA_LOW_INVERT
    |=> rd_valid_o && rd_dq_o == 8'h00 && invert_r == $past(invert_r))
    else $error("write-only read not zero or had side effect");
  a_read_count_lo: assert property ( // RQ12
    take && code_s == DCI_CMD_MRR && addr_s == `DCI_MA_CNT_LOW |=> rd_valid_o && rd_dq_o == $past(cnt_lo_r))
    else $error("count low byte read wrong");
  a_osc_load: assert property ( // RQ12
    osc_done_i |=> cnt_lo_r == $past(osc_count_i[7:0]) && cnt_hi_r == $past(osc_count_i[15:8]))
    else $error("oscillator count not loaded");
  a_seg_other_chan: assert property ( // RQ10
    take && code_s == DCI_CMD_MRW && addr_s == `DCI_MA_SEG_MASK
    |=> seg_r[!$past(chan_s)] == $past(seg_r[!chan_s]))
    else $error("segment mask written to other channel");
  a_skip_idle: assert property ( // RQ6
    !rfq_valid_i |=> !rfq_skip_o)
    else $error("refresh skip without a query");
endmodule

/* File: core/dci_regs.svh */
// constants of the calibration-invert, partial refresh mask and oscillator count mode registers
// assumes: included by the main module by bare name; types live in dci_pkg
// Notes on behaviour
// [RQ1] invert bit n flips the calibration pattern on low-byte lane n
// [RQ2] inversion applies to both calibration patterns, any lane combination
// [RQ3] invert register resets to 55h, lanes 0, 2, 4, 6 inverted
// [RQ4] mask/inversion lane always carries the true pattern bit
// [RQ5] no bus inversion during read calibration even when enabled
// [RQ6] bank mask bit n set disables refresh of bank n; resets to zero
// [RQ7] bank masks are held separately for each channel
// [RQ8] segment mask bit n set disables refresh of segment n; resets zero
// [RQ9] segment is the top three row bits, chosen by channel density
// [RQ10] segment masks are held separately for each channel
// [RQ11] controller writes segment bits 7:6 as zero for 3, 6, 12Gb
// [RQ12] count reported as low byte and high byte read-only registers
// [RQ13] controller reads both count registers and joins them
// [RQ14] start-oscillator command clears both count registers; a run finishing in the same cycle is loaded instead
// [RQ15] controller may use the count to retune strobe phase
// [RQ16] register read drives eight bits on lanes 7:0, unused bits zero
// [RQ17] reads of write-only registers return zero without side effects
`ifndef DCI_REGS_SVH
`define DCI_REGS_SVH
`define DCI_MA_LOW_INVERT 6'h0F
`define DCI_MA_BANK_MASK  6'h10
`define DCI_MA_SEG_MASK   6'h11
`define DCI_MA_CNT_LOW    6'h12
`define DCI_MA_CNT_HIGH   6'h13
`define DCI_INVERT_RST    8'h55
`define DCI_MASK_RST      8'h00
`define DCI_CNT_RST       8'h00
`define DCI_DBI_ONES_MAX  4'h4
`endif

/* File: core/dci_pkg.sv */
// types and helpers shared by the mode register block and its calibration lane driver
// assumes: compiled before every other design file
package dci_pkg;
  typedef enum logic [1:0] {
    DCI_CMD_NOP     = 2'b00,
    DCI_CMD_MRW     = 2'b01,
    DCI_CMD_MRR     = 2'b10,
    DCI_CMD_OSC_MPC = 2'b11
  } dci_cmd_type;

  typedef logic [7:0] dci_byte_type;

  // density code 0..7 = 1,2,3,4,6,8,12,16 Gb per channel
  function automatic logic [2:0] dci_seg_of(input logic [2:0] dens, input logic [16:0] row);
    logic [2:0] seg;
    seg = row[16:14];
    case (dens)
      3'h0: seg = row[12:10];
      3'h1: seg = row[13:11];
      3'h2, 3'h3: seg = row[14:12];
      3'h4, 3'h5: seg = row[15:13];
      default: seg = row[16:14];
    endcase
    return seg;
  endfunction

  function automatic logic [3:0] dci_ones(input dci_byte_type b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, b[i]};
    end
    return n;
  endfunction
endpackage

/* File: core/dci_cal_if.sv */
// carries the invert mask, pattern bits and lane results between top and lane driver
// assumes: one clock domain, driven by dci_top
interface dci_cal_if;
  logic [7:0] invert_mask;
  logic       cal_active;
  logic       pat_sel_b;
  logic       pat_a_bit;
  logic       pat_b_bit;
  logic       bus_inv_en;
  logic [7:0] rd_byte;
  logic [7:0] dq_lane;
  logic       mask_lane;
  modport ctrl (output invert_mask, cal_active, pat_sel_b, pat_a_bit, pat_b_bit, bus_inv_en, rd_byte,
                input dq_lane, mask_lane);
  modport lane (input invert_mask, cal_active, pat_sel_b, pat_a_bit, pat_b_bit, bus_inv_en, rd_byte,
                output dq_lane, mask_lane);
endinterface

/* File: core/dci_cal_lane.sv */
// low-byte lane driver: calibration pattern with per-lane inversion, or read data with bus inversion
// assumes: all inputs come from logic on ref_clk_i
`include "dci_regs.svh"
module dci_cal_lane
  import dci_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  dci_cal_if.lane   cal
);
  logic [7:0] dq_r;
  logic [7:0] dq_nxt;
  logic       mask_r;
  logic       mask_nxt;
  logic       pat_bit;
  logic       dbi_hit;

  always_comb begin
    pat_bit  = cal.pat_sel_b ? cal.pat_b_bit : cal.pat_a_bit;                  // RQ2
    dbi_hit  = cal.bus_inv_en && (dci_ones(cal.rd_byte) > `DCI_DBI_ONES_MAX);
    dq_nxt   = dbi_hit ? ~cal.rd_byte : cal.rd_byte;
    mask_nxt = dbi_hit;
    if (cal.cal_active) begin
      dq_nxt   = {8{pat_bit}} ^ cal.invert_mask;                               // RQ1
      mask_nxt = pat_bit;                                                      // RQ4 RQ5
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dq_r   <= 8'h00;
      mask_r <= 1'b0;
    end else begin
      dq_r   <= dq_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign cal.dq_lane   = dq_r;
  assign cal.mask_lane = mask_r;

  a_cal_lane_invert: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ1
    cal.cal_active |=> cal.dq_lane == ({8{$past(pat_bit)}} ^ $past(cal.invert_mask)))
    else $error("calibration lane inversion wrong");
  a_pattern_b_used: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ2
    cal.cal_active && cal.pat_sel_b && cal.invert_mask == 8'h00 |=> cal.dq_lane == {8{$past(cal.pat_b_bit)}})
    else $error("second pattern not driven");
  a_mask_lane_true: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ4
    cal.cal_active |=> cal.mask_lane == $past(pat_bit))
    else $error("mask lane inverted during calibration");
  a_no_dbi_cal: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RQ5
    cal.cal_active && cal.bus_inv_en && cal.invert_mask == 8'h00 ##1 cal.cal_active && cal.invert_mask == 8'h00
    |-> cal.dq_lane == {8{$past(pat_bit)}} ##1 cal.dq_lane == {8{$past(pat_bit)}})
    else $error("bus inversion applied during calibration");
endmodule

/* File: verif/dci_ctrl_model.sv */
// controller-side model: drives the command pins and the command clock pin for one command at a time
// assumes: the bench calls issue() from its main sequence; the clock pin stands still between commands
module dci_ctrl_model
  import dci_pkg::*;
(
  output logic       ck_o,
  output logic       cmd_valid_o,
  output logic [1:0] cmd_code_o,
  output logic       cmd_chan_o,
  output logic [5:0] cmd_addr_o,
  output logic [7:0] cmd_op_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    ck_o = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_code_o = 2'h0;
    cmd_chan_o = 1'b0;
    cmd_addr_o = 6'h00;
    cmd_op_o = 8'h00;
  end

  // a start-oscillator command is the only way the controller clears the counts
  // segment bits 7:6 are left to the caller, which keeps them zero for 3/6/12Gb
  // the count may be used to retune strobe phase; the bench only reads both halves
  // non-blocking drives keep a pin change that lands on a block clock edge free of races
  task automatic issue(input dci_cmd_type code, input logic ch, input logic [5:0] a, input logic [7:0] op);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= code;
    cmd_chan_o <= ch;
    cmd_addr_o <= a;
    cmd_op_o <= op;
    #16;
    ck_o <= 1'b1;
    #24;
    ck_o <= 1'b0;
    #8;
    // released pins show the inverse so a stale value is never mistaken for a held one
    cmd_valid_o <= 1'b0;
    cmd_code_o <= ~code;
    cmd_chan_o <= ~ch;
    cmd_addr_o <= ~a;
    cmd_op_o <= ~op;
  endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the mode register block: commands, refresh queries, oscillator count and lanes
// assumes: dci_pkg and the design files are compiled first; two channels
module tb;
  import dci_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic            ref_clk_i = 1'b0;
  logic            reset_i;
  logic            ck_i, cmd_valid_i, cmd_chan_i, rd_valid_o, osc_done_i, rfq_valid_i, rfq_chan_i, rfq_skip_o;
  logic [1:0]      cmd_code_i;
  logic [5:0]      cmd_addr_i;
  logic [7:0]      cmd_op_i, rd_dq_o, rd_byte_i, dq_lane_o, rd_last;
  logic [15:0]     osc_count_i;
  logic [1:0][2:0] density_i;
  logic [2:0]      rfq_bank_i;
  logic [16:0]     rfq_row_i;
  logic [1:0][7:0] bank_mask_o, seg_mask_o;
  logic            cal_active_i, cal_pat_sel_b_i, cal_pat_a_bit_i, cal_pat_b_bit_i, bus_inv_en_i, mask_lane_o;
  int              miscompares = 0;
  int              total_checks = 0;
  int              rd_cnt = 0;
  int              cycles = 0;
  int              lsb [8] = '{10, 11, 12, 12, 13, 13, 14, 14};

  always #2.5 ref_clk_i = ~ref_clk_i;

  dci_ctrl_model ctrl (.ck_o(ck_i), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i), .cmd_chan_o(cmd_chan_i),
                       .cmd_addr_o(cmd_addr_i), .cmd_op_o(cmd_op_i));

  dci_top #(.NUM_CH(2)) uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ck_i(ck_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .cmd_chan_i(cmd_chan_i), .cmd_addr_i(cmd_addr_i), .cmd_op_i(cmd_op_i),
    .rd_valid_o(rd_valid_o), .rd_dq_o(rd_dq_o), .osc_done_i(osc_done_i), .osc_count_i(osc_count_i),
    .density_i(density_i), .rfq_valid_i(rfq_valid_i), .rfq_chan_i(rfq_chan_i), .rfq_bank_i(rfq_bank_i),
    .rfq_row_i(rfq_row_i), .rfq_skip_o(rfq_skip_o), .bank_mask_o(bank_mask_o), .seg_mask_o(seg_mask_o),
    .cal_active_i(cal_active_i), .cal_pat_sel_b_i(cal_pat_sel_b_i), .cal_pat_a_bit_i(cal_pat_a_bit_i),
    .cal_pat_b_bit_i(cal_pat_b_bit_i), .bus_inv_en_i(bus_inv_en_i), .rd_byte_i(rd_byte_i),
    .dq_lane_o(dq_lane_o), .mask_lane_o(mask_lane_o));

  // the read pulse stands one cycle, so it is caught here while the command task is still running
  always @(posedge ref_clk_i) begin
    cycles++;
    if (rd_valid_o === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
      rd_last <= rd_dq_o;
    end
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report;
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cmd(input dci_cmd_type code, input logic ch, input logic [5:0] a, input logic [7:0] op);
    ctrl.issue(code, ch, a, op);
    repeat (4) @(posedge ref_clk_i);
  endtask

  task automatic mrr(input logic ch, input logic [5:0] a, input logic [7:0] exp);
    int n;
    n = rd_cnt;
    cmd(DCI_CMD_MRR, ch, a, 8'h00);
    check("read pulses", 8'(rd_cnt - n), 8'h01);
    check("read data", rd_last, exp);
  endtask

  task automatic lane(input logic sel, input logic pa, input logic pb, input logic [7:0] exp_dq, input logic exp_m);
    @(posedge ref_clk_i);
    cal_active_i <= 1'b1;
    cal_pat_sel_b_i <= sel;
    cal_pat_a_bit_i <= pa;
    cal_pat_b_bit_i <= pb;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("dq lanes", dq_lane_o, exp_dq);
    check("mask lane", {7'h00, mask_lane_o}, {7'h00, exp_m});
  endtask

  task automatic query(input logic ch, input logic [2:0] bank, input logic [16:0] row, input logic exp);
    @(posedge ref_clk_i);
    rfq_valid_i <= 1'b1;
    rfq_chan_i <= ch;
    rfq_bank_i <= bank;
    rfq_row_i <= row;
    @(posedge ref_clk_i);
    rfq_valid_i <= 1'b0;
    // the answer stands for one cycle only, so it is read just after the edge that launches it
    #1;
    check("refresh skip", {7'h00, rfq_skip_o}, {7'h00, exp});
  endtask

  initial begin
    reset_i = 1'b1;
    {osc_done_i, rfq_valid_i, rfq_chan_i, cal_active_i, cal_pat_sel_b_i, cal_pat_a_bit_i, cal_pat_b_bit_i} = '0;
    osc_count_i = 16'h0000;
    density_i = '0;
    rfq_bank_i = 3'h0;
    rfq_row_i = 17'h00000;
    rd_byte_i = 8'h1F;
    bus_inv_en_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    check("bank mask ch0", bank_mask_o[0], 8'h00);
    check("seg mask ch1", seg_mask_o[1], 8'h00);
    mrr(1'b0, 6'h0F, 8'h00);
    mrr(1'b0, 6'h12, 8'h00);
    // bus inversion stays off although enabled: five ones would otherwise flip the byte
    lane(1'b0, 1'b1, 1'b0, 8'hAA, 1'b1);
    cmd(DCI_CMD_MRW, 1'b0, 6'h0F, 8'h15);
    lane(1'b1, 1'b0, 1'b1, 8'hEA, 1'b1);
    lane(1'b1, 1'b1, 1'b0, 8'h15, 1'b0);
    lane(1'b0, 1'b0, 1'b1, 8'h15, 1'b0);
    mrr(1'b0, 6'h0F, 8'h00);
    cmd(DCI_CMD_NOP, 1'b0, 6'h0F, 8'h00);
    lane(1'b0, 1'b1, 1'b0, 8'hEA, 1'b1);
    cmd(DCI_CMD_MRW, 1'b0, 6'h0F, 8'h00);
    lane(1'b1, 1'b0, 1'b1, 8'hFF, 1'b1);
    lane(1'b1, 1'b1, 1'b0, 8'h00, 1'b0);
    // outside calibration the same byte is flipped, which shows the enable is live
    @(posedge ref_clk_i);
    cal_active_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("dq lanes", dq_lane_o, 8'hE0);
    check("mask lane", {7'h00, mask_lane_o}, 8'h01);
    cmd(DCI_CMD_MRW, 1'b0, 6'h10, 8'hA5);
    cmd(DCI_CMD_MRW, 1'b1, 6'h10, 8'h5A);
    check("bank mask ch0", bank_mask_o[0], 8'hA5);
    check("bank mask ch1", bank_mask_o[1], 8'h5A);
    query(1'b0, 3'h0, 17'h00000, 1'b1);
    query(1'b0, 3'h1, 17'h00000, 1'b0);
    cmd(DCI_CMD_MRW, 1'b1, 6'h11, 8'h04);
    cmd(DCI_CMD_MRW, 1'b0, 6'h14, 8'hFF);
    check("seg mask ch1", seg_mask_o[1], 8'h04);
    check("seg mask ch0", seg_mask_o[0], 8'h00);
    check("bank mask ch0", bank_mask_o[0], 8'hA5);
    for (int d = 0; d < 8; d++) begin
      @(posedge ref_clk_i);
      density_i[1] <= 3'(d);
      query(1'b1, 3'h0, 17'h00002 << lsb[d], 1'b1);
      query(1'b1, 3'h0, 17'h00001 << lsb[d], 1'b0);
    end
    @(posedge ref_clk_i);
    osc_count_i <= 16'hBEEF;
    osc_done_i <= 1'b1;
    @(posedge ref_clk_i);
    osc_done_i <= 1'b0;
    mrr(1'b0, 6'h12, 8'hEF);
    mrr(1'b0, 6'h13, 8'hBE);
    cmd(DCI_CMD_OSC_MPC, 1'b0, 6'h00, 8'h00);
    mrr(1'b0, 6'h12, 8'h00);
    mrr(1'b0, 6'h13, 8'h00);
    final_report();
  end
endmodule
